// file: uacs_pkg.sv
package uacs_pkg;

   // Register byte offsets
   localparam logic [7:0]  UACS_OFF_P3L    = 8'h00;
   localparam logic [7:0]  UACS_OFF_P3H    = 8'h04;
   localparam logic [7:0]  UACS_OFF_TXSUM  = 8'h08;
   localparam logic [7:0]  UACS_OFF_RXSUM  = 8'h0C;
   localparam logic [7:0]  UACS_OFF_SCCFG  = 8'h10;
   localparam logic [7:0]  UACS_OFF_SCIRQ  = 8'h14;
   localparam logic [7:0]  UACS_OFF_WAKEAB = 8'h18;
   localparam logic [7:0]  UACS_OFF_CTRL   = 8'h1C;

   // Writable bit masks; everything else reads zero
   localparam logic [15:0] UACS_MSK_P3L    = 16'hFFFF;
   localparam logic [15:0] UACS_MSK_P3H    = 16'h00FF;
   localparam logic [15:0] UACS_MSK_SUM    = 16'h00FF;
   localparam logic [15:0] UACS_MSK_SCCFG  = 16'h003E;
   localparam logic [15:0] UACS_MSK_SCIRQ  = 16'h3737;
   localparam logic [15:0] UACS_MSK_WAKEAB = 16'h00C4;
   localparam logic [15:0] UACS_MSK_CTRL   = 16'h003F;
   localparam logic [15:0] UACS_REG_RST    = 16'h0000;

   // Field positions
   localparam int UACS_CTRL_MODE_LSB = 0;
   localparam int UACS_CTRL_WAKE     = 3;
   localparam int UACS_CTRL_ABD      = 4;
   localparam int UACS_CTRL_CINC     = 5;
   localparam int UACS_SCC_PROTO     = 1;
   localparam int UACS_SCC_PULL      = 2;
   localparam int UACS_SCC_LOGIC_CONVENTION      = 3;
   localparam int UACS_SCC_RPT_LSB   = 4;
   localparam int UACS_SCI_GT_IF     = 8;
   localparam int UACS_SCI_WT_IF     = 9;
   localparam int UACS_SCI_BT_IF     = 10;
   localparam int UACS_SCI_TXR_IF    = 12;
   localparam int UACS_SCI_RXR_IF    = 13;
   localparam int UACS_SCI_IE_SHIFT  = 8;
   localparam int UACS_WA_WAKE_IF    = 7;
   localparam int UACS_WA_ABD_IF     = 6;
   localparam int UACS_WA_ABD_IE     = 2;

   // Counts
   localparam logic [2:0]  UACS_RX_TRIES_M1 = 3'h4;
   localparam logic [2:0]  UACS_ABD_FALLS   = 3'h5;
   localparam logic [1:0]  UACS_PULL_SHORT  = 2'h1;
   localparam logic [1:0]  UACS_PULL_LONG   = 2'h2;
   localparam int          UACS_NTMR        = 3;

   typedef enum logic [2:0] {
      UACS_ASYNC, UACS_ADDR, UACS_DMX_RX, UACS_LIN_CMD, UACS_LIN_RSP, UACS_CARD
   } uacs_mode_t;

   typedef struct packed {
      logic       stb;
      logic       is_id;
      logic [7:0] data;
   } uacs_byte_ev_t;

   typedef struct packed {
      logic etu_tick;
      logic gt_start;
      logic wt_start;
      logic bt_start;
      logic rx_par_err;
      logic rx_char_ok;
      logic tx_line_err;
      logic tx_char_ok;
   } uacs_card_ev_t;

   typedef struct packed {
      logic [15:0]                  p3l;
      logic [15:0]                  p3h;
      logic [15:0]                  tx_sum;
      logic [15:0]                  rx_sum;
      logic [15:0]                  sccfg;
      logic [15:0]                  scirq;
      logic [15:0]                  wakeab;
      logic [15:0]                  ctrl;
      logic [2:0]                   rx_sync;
      logic                         rx_lvl;
      logic [2:0]                   abd_falls;
      logic [UACS_NTMR-1:0][23:0]   tmr;
      logic [UACS_NTMR-1:0]         tmr_run;
      logic [2:0]                   retx_cnt;
      logic [2:0]                   rxerr_cnt;
      logic [1:0]                   pull_cnt;
      logic                         retx_req;
      logic                         abd_done;
      logic [7:0]                   card_data;
      logic [31:0]                  prdata;
   } uacs_state_t;

endpackage : uacs_pkg

// file: uacs_core.sv
`timescale 1ns/10ps
`default_nettype none

module uacs_core
   import uacs_pkg::*;
(
   // Clock and reset
   input  wire logic           CORE_CLK,
   input  wire logic           NRST,
   // APB slave
   input  wire logic           PSEL,
   input  wire logic           PENABLE,
   input  wire logic           PWRITE,
   input  wire logic [7:0]     PADDR,
   input  wire logic [31:0]    PWDATA,
   output logic [31:0]         PRDATA,
   output logic                PREADY,
   output logic                PSLVERR,
   // Byte events from the serial engine
   input  wire uacs_byte_ev_t  TX_EV,
   input  wire uacs_byte_ev_t  RX_EV,
   input  wire logic           BREAK_DET,
   // Receive line pin
   input  wire logic           RX_PIN,
   // Card timing from the engine
   input  wire uacs_card_ev_t  CARD_EV,
   input  wire logic [8:0]     PARAM_ONE,
   input  wire logic [8:0]     PARAM_TWO,
   // Mode-dependent parameter views
   output logic [8:0]          DMX_LAST_IDX,
   output logic [7:0]          LIN_RX_COUNT,
   output logic [7:0]          ADDR_MASK,
   output logic [23:0]         WAIT_TIME,
   // Card line control
   output logic                CARD_RETX_REQ,
   output logic                CARD_LINE_LOW,
   output logic                CARD_PROTO_T1,
   output logic                CARD_LOGIC_CONVENTION_INV,
   output logic [7:0]          CARD_RX_DATA,
   // Event outputs
   output logic                AUTOBAUD_DONE,
   output logic                CARD_IRQ,
   output logic                EVENT_IRQ
);

   uacs_state_t r;
   uacs_state_t nxt;

   // Ones-complement style byte add, carry folded back in
   function automatic logic [7:0] sum_fold(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [8:0] t;
      s = {1'b0, a} + {1'b0, b};
      t = {1'b0, s[7:0]} + {8'h00, s[8]};
      return t[7:0];
   endfunction : sum_fold

   // Inverse convention: bits inverted and sent msb first
   function automatic logic [7:0] logic_convention_byte(input logic [7:0] d, input logic inv);
      logic [7:0] o;
      o = d;
      if (inv) begin
         for (int k = 0; k < 8; k++) begin
            o[k] = ~d[7-k];
         end
      end
      return o;
   endfunction : logic_convention_byte

   function automatic logic [15:0] read_mux(input uacs_state_t s, input logic [7:0] a);
      logic [15:0] v;
      v = 16'h0000;
      case (a)
         UACS_OFF_P3L:    v = s.p3l;
         UACS_OFF_P3H:    v = s.p3h;
         UACS_OFF_TXSUM:  v = s.tx_sum;
         UACS_OFF_RXSUM:  v = s.rx_sum;
         UACS_OFF_SCCFG:  v = s.sccfg;
         UACS_OFF_SCIRQ:  v = s.scirq;
         UACS_OFF_WAKEAB: v = s.wakeab;
         UACS_OFF_CTRL:   v = s.ctrl;
         default:         v = 16'h0000;
      endcase
      return v;
   endfunction : read_mux

   logic        mapped;
   logic        wr_en;
   uacs_mode_t  mode;
   logic        lin_mode;
   logic        card_mode;
   logic        cinc;
   logic [1:0]  rpt_sel;
   logic [2:0]  retx_limit;
   logic        rx_fall;
   logic        new_lvl;
   logic [UACS_NTMR-1:0]       tmr_start;
   logic [UACS_NTMR-1:0][23:0] tmr_load;
   logic [UACS_NTMR-1:0]       tmr_flag;

   always_comb begin
      mapped = (PADDR[1:0] == 2'h0) && (PADDR <= UACS_OFF_CTRL);
      wr_en  = PSEL && PENABLE && PWRITE && mapped;
      case (r.ctrl[UACS_CTRL_MODE_LSB +: 3])
         3'h1:    mode = UACS_ADDR;
         3'h2:    mode = UACS_DMX_RX;
         3'h3:    mode = UACS_LIN_CMD;
         3'h4:    mode = UACS_LIN_RSP;
         3'h5:    mode = UACS_CARD;
         default: mode = UACS_ASYNC;
      endcase
      lin_mode   = (mode == UACS_LIN_CMD) || (mode == UACS_LIN_RSP);
      card_mode  = (mode == UACS_CARD);
      cinc       = r.ctrl[UACS_CTRL_CINC];
      rpt_sel    = r.sccfg[UACS_SCC_RPT_LSB +: 2];
      retx_limit = {1'b0, rpt_sel} + 3'h1;
      tmr_start  = {CARD_EV.bt_start, CARD_EV.wt_start, CARD_EV.gt_start};
      // Guard, wait, block in that order
      tmr_load[0] = {15'h0000, PARAM_ONE};
      tmr_load[1] = {r.p3h[7:0], r.p3l};
      tmr_load[2] = {15'h0000, PARAM_TWO};
   end

   always_comb begin
      nxt = r;
      tmr_flag = '0;
      nxt.retx_req = 1'b0;
      nxt.abd_done = 1'b0;

      // Read data captured in the setup phase, so the access phase needs no wait
      if (PSEL && !PENABLE) begin
         nxt.prdata = {16'h0000, read_mux(r, PADDR)};
      end

      // Software writes first; hardware events below override them
      if (wr_en) begin
         case (PADDR)
            UACS_OFF_P3L:    nxt.p3l    = PWDATA[15:0] & UACS_MSK_P3L;
            UACS_OFF_P3H:    nxt.p3h    = PWDATA[15:0] & UACS_MSK_P3H;
            UACS_OFF_TXSUM:  nxt.tx_sum = PWDATA[15:0] & UACS_MSK_SUM;
            UACS_OFF_RXSUM:  nxt.rx_sum = PWDATA[15:0] & UACS_MSK_SUM;
            UACS_OFF_SCCFG:  nxt.sccfg  = PWDATA[15:0] & UACS_MSK_SCCFG;
            UACS_OFF_SCIRQ:  nxt.scirq  = PWDATA[15:0] & UACS_MSK_SCIRQ;
            UACS_OFF_WAKEAB: nxt.wakeab = PWDATA[15:0] & UACS_MSK_WAKEAB;
            UACS_OFF_CTRL:   nxt.ctrl   = PWDATA[15:0] & UACS_MSK_CTRL;
            default:         nxt.ctrl   = r.ctrl;
         endcase
      end

      // Receive pin: three stages, a change counts once stages two and three agree
      nxt.rx_sync = {r.rx_sync[1:0], RX_PIN};
      new_lvl = r.rx_lvl;
      if (r.rx_sync[1] == r.rx_sync[2]) begin
         new_lvl = r.rx_sync[2];
      end
      nxt.rx_lvl = new_lvl;
      rx_fall = r.rx_lvl && !new_lvl;

      if (rx_fall && r.ctrl[UACS_CTRL_WAKE]) begin
         nxt.wakeab[UACS_WA_WAKE_IF] = 1'b1;
      end

      // Sync pattern has a fixed number of falling edges; the last ends measurement
      if (!r.ctrl[UACS_CTRL_ABD]) begin
         nxt.abd_falls = 3'h0;
      end else if (rx_fall) begin
         if (r.abd_falls == UACS_ABD_FALLS - 3'h1) begin
            nxt.abd_falls = 3'h0;
            nxt.abd_done  = 1'b1;
            nxt.ctrl[UACS_CTRL_ABD] = 1'b0;
            nxt.wakeab[UACS_WA_ABD_IF] = 1'b1;
         end else begin
            nxt.abd_falls = r.abd_falls + 3'h1;
         end
      end

      // Checksums
      if (lin_mode && BREAK_DET) begin
         nxt.tx_sum = UACS_REG_RST;
         nxt.rx_sum = UACS_REG_RST;
      end else if (lin_mode) begin
         if (TX_EV.stb && (cinc || !TX_EV.is_id)) begin
            nxt.tx_sum = {8'h00, sum_fold(r.tx_sum[7:0], TX_EV.data)};
         end
         if (RX_EV.stb && (cinc || !RX_EV.is_id)) begin
            nxt.rx_sum = {8'h00, sum_fold(r.rx_sum[7:0], RX_EV.data)};
         end
      end else if (cinc) begin
         if (TX_EV.stb) begin
            nxt.tx_sum = {8'h00, sum_fold(r.tx_sum[7:0], TX_EV.data)};
         end
         if (RX_EV.stb) begin
            nxt.rx_sum = {8'h00, sum_fold(r.rx_sum[7:0], RX_EV.data)};
         end
      end

      if (card_mode && RX_EV.stb) begin
         nxt.card_data = logic_convention_byte(RX_EV.data, r.sccfg[UACS_SCC_LOGIC_CONVENTION]);
      end

      // Card timers
      for (int i = 0; i < UACS_NTMR; i++) begin
         if (!card_mode) begin
            nxt.tmr_run[i] = 1'b0;
         end else if (tmr_start[i]) begin
            nxt.tmr[i] = tmr_load[i];
            nxt.tmr_run[i] = (tmr_load[i] != 24'h000000);
            tmr_flag[i] = (tmr_load[i] == 24'h000000);
         end else if (r.tmr_run[i] && CARD_EV.etu_tick) begin
            nxt.tmr[i] = r.tmr[i] - 24'h000001;
            if (r.tmr[i] == 24'h000001) begin
               nxt.tmr_run[i] = 1'b0;
               tmr_flag[i] = 1'b1;
            end
         end
      end
      if (tmr_flag[0]) begin
         nxt.scirq[UACS_SCI_GT_IF] = 1'b1;
      end
      if (tmr_flag[1]) begin
         nxt.scirq[UACS_SCI_WT_IF] = 1'b1;
      end
      if (tmr_flag[2]) begin
         nxt.scirq[UACS_SCI_BT_IF] = 1'b1;
      end

      // Transmit side repeats
      if (card_mode && CARD_EV.tx_line_err) begin
         if (r.retx_cnt < retx_limit) begin
            nxt.retx_req = 1'b1;
            nxt.retx_cnt = r.retx_cnt + 3'h1;
         end else begin
            nxt.retx_cnt = 3'h0;
            nxt.scirq[UACS_SCI_TXR_IF] = 1'b1;
         end
      end else if (CARD_EV.tx_char_ok || !card_mode) begin
         nxt.retx_cnt = 3'h0;
      end

      // Receive side repeats and T=0 error pull-down
      if (card_mode && CARD_EV.rx_par_err) begin
         if (r.rxerr_cnt == UACS_RX_TRIES_M1) begin
            nxt.rxerr_cnt = 3'h0;
            nxt.scirq[UACS_SCI_RXR_IF] = 1'b1;
         end else begin
            nxt.rxerr_cnt = r.rxerr_cnt + 3'h1;
         end
      end else if (CARD_EV.rx_char_ok || !card_mode) begin
         nxt.rxerr_cnt = 3'h0;
      end

      // T=1 signals errors by block, not by holding the line
      if (card_mode && CARD_EV.rx_par_err && !r.sccfg[UACS_SCC_PROTO]) begin
         nxt.pull_cnt = r.sccfg[UACS_SCC_PULL] ? UACS_PULL_LONG : UACS_PULL_SHORT;
      end else if (!card_mode) begin
         nxt.pull_cnt = 2'h0;
      end else if (r.pull_cnt != 2'h0 && CARD_EV.etu_tick) begin
         nxt.pull_cnt = r.pull_cnt - 2'h1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   // Bus answers: zero wait, error on unmapped word
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA  = r.prdata;

   // Parameter three views; consumers use the one for their mode
   assign DMX_LAST_IDX = r.p3l[8:0];
   assign LIN_RX_COUNT = r.p3l[7:0];
   assign ADDR_MASK    = r.p3l[7:0];
   assign WAIT_TIME    = {r.p3h[7:0], r.p3l};

   assign CARD_RETX_REQ = r.retx_req;
   assign CARD_LINE_LOW = (r.pull_cnt != 2'h0);
   assign CARD_PROTO_T1 = r.sccfg[UACS_SCC_PROTO];
   assign CARD_LOGIC_CONVENTION_INV = r.sccfg[UACS_SCC_LOGIC_CONVENTION];
   assign CARD_RX_DATA  = r.card_data;
   assign AUTOBAUD_DONE = r.abd_done;

   assign CARD_IRQ  = |(r.scirq[UACS_SCI_RXR_IF:UACS_SCI_GT_IF]
                        & r.scirq[UACS_SCI_RXR_IF-UACS_SCI_IE_SHIFT:0]);
   assign EVENT_IRQ = r.wakeab[UACS_WA_WAKE_IF]
                      | (r.wakeab[UACS_WA_ABD_IF] & r.wakeab[UACS_WA_ABD_IE]);

endmodule : uacs_core

`default_nettype wire

// file: uacs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module uacs_checker
   import uacs_pkg::*;
(
   // Clock and reset
   input wire logic          CORE_CLK,
   input wire logic          NRST,
   // Register bus
   input wire logic          PSEL,
   input wire logic          PENABLE,
   input wire logic          PWRITE,
   input wire logic [7:0]    PADDR,
   input wire logic [31:0]   PWDATA,
   input wire logic [31:0]   PRDATA,
   input wire logic          PSLVERR,
   // Card and views
   input wire uacs_card_ev_t CARD_EV,
   input wire logic [8:0]    DMX_LAST_IDX,
   input wire logic [7:0]    LIN_RX_COUNT,
   input wire logic [7:0]    ADDR_MASK,
   input wire logic [23:0]   WAIT_TIME,
   input wire logic          CARD_RETX_REQ,
   input wire logic          CARD_LINE_LOW,
   input wire logic          AUTOBAUD_DONE
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   sequence s_acc;
      PSEL && PENABLE;
   endsequence
   sequence s_p3l_wr;
      s_acc ##0 PWRITE && PADDR == UACS_OFF_P3L;
   endsequence
   sequence s_p3h_wr;
      s_acc ##0 PWRITE && PADDR == UACS_OFF_P3H;
   endsequence

   a_p3_low_load: assert property (s_p3l_wr |=> WAIT_TIME[15:0] == $past(PWDATA[15:0]))
      else $error("wait time low half not loaded");
   a_p3_high_load: assert property (s_p3h_wr |=> WAIT_TIME[23:16] == $past(PWDATA[7:0]))
      else $error("wait time high byte not loaded");
   a_dmx_view: assert property (s_p3l_wr |=> DMX_LAST_IDX == $past(PWDATA[8:0]))
      else $error("dmx last index differs");
   a_lin_view: assert property (s_p3l_wr |=> LIN_RX_COUNT == $past(PWDATA[7:0]))
      else $error("lin count differs");
   a_mask_view: assert property (s_p3l_wr |=> ADDR_MASK == $past(PWDATA[7:0]))
      else $error("address mask differs");
   a_unmapped_read: assert property (s_acc ##0 !PWRITE && (PADDR > UACS_OFF_CTRL || PADDR[1:0] != 2'h0)
      |-> PSLVERR && PRDATA == 32'h00000000)
      else $error("unmapped read not refused");
   a_upper_zero: assert property (PRDATA[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_retx_cause: assert property (CARD_RETX_REQ |-> $past(CARD_EV.tx_line_err) && !$past(CARD_RETX_REQ))
      else $error("resend without line error");
   a_low_cause: assert property ($rose(CARD_LINE_LOW) |-> $past(CARD_EV.rx_par_err))
      else $error("line pulled low without parity error");
   a_abd_pulse: assert property (AUTOBAUD_DONE |=> !AUTOBAUD_DONE)
      else $error("auto-baud done longer than one cycle");
endmodule : uacs_checker
`default_nettype wire

// file: uacs_line_node.sv
`timescale 1ns/10ps
`default_nettype none
module uacs_line_node (
   // Control
   input wire logic       clk,
   input wire logic       go,
   input wire logic [2:0] n,
   // Line
   output logic           rx_pin,
   output logic           busy
);
   initial begin
      rx_pin = 1'b1;
      busy = 1'b0;
   end
   // Idle line rests high; each fall held long enough for the filter
   always @(posedge clk) begin
      if (go) begin
         busy <= 1'b1;
         repeat (n) begin
            rx_pin <= 1'b0;
            repeat (6) @(posedge clk);
            rx_pin <= 1'b1;
            repeat (6) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule : uacs_line_node
`default_nettype wire

// file: uacs_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uacs_core_tb
   import uacs_pkg::*;
;
   logic          clk, nrst, psel, penable, pwrite, brk, rxp, go, busy;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, q;
   logic          pready, pslverr, retx, llow, t1, inv, abd, cirq, eirq;
   uacs_byte_ev_t tx_ev, rx_ev;
   uacs_card_ev_t cev;
   logic [8:0]    p1, p2, dmx;
   logic [7:0]    linc, amsk, crx, e;
   logic [23:0]   wt;
   logic [2:0]    nf;
   logic [15:0]   msk [8];
   logic [15:0]   cv [6];
   int            n_errors, samples_checked, n_retx, n_abd, lowticks;

   uacs_core i_dut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TX_EV(tx_ev), .RX_EV(rx_ev), .BREAK_DET(brk), .RX_PIN(rxp), .CARD_EV(cev), .PARAM_ONE(p1),
      .PARAM_TWO(p2), .DMX_LAST_IDX(dmx), .LIN_RX_COUNT(linc), .ADDR_MASK(amsk), .WAIT_TIME(wt),
      .CARD_RETX_REQ(retx), .CARD_LINE_LOW(llow), .CARD_PROTO_T1(t1), .CARD_LOGIC_CONVENTION_INV(inv),
      .CARD_RX_DATA(crx), .AUTOBAUD_DONE(abd), .CARD_IRQ(cirq), .EVENT_IRQ(eirq));
   uacs_line_node i_node (.clk(clk), .go(go), .n(nf), .rx_pin(rxp), .busy(busy));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counted at the falling edge, away from the design's own updates
   always @(negedge clk) begin
      if (retx === 1'b1) n_retx++;
      if (abd === 1'b1) n_abd++;
      if (llow === 1'b1 && cev.etu_tick === 1'b1) lowticks++;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 16);
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
      if (pready !== 1'b1) begin n_errors++; conclude(); end
   endtask : apb
   task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] x);
      apb(1'b0, a, 16'h0000);
      chk(nm, {16'h0000, x}, q);
   endtask : rdc
   task automatic cp(input logic [7:0] v);
      @(posedge clk) cev <= uacs_card_ev_t'(v);
      @(posedge clk) cev <= '0;
   endtask : cp
   task automatic bev(input logic id, input logic [7:0] d);
      @(posedge clk) begin tx_ev <= '{1'b1, id, d}; rx_ev <= '{1'b1, id, d}; end
      @(posedge clk) begin tx_ev <= '0; rx_ev <= '0; end
   endtask : bev
   task automatic line(input logic [2:0] n);
      int k;
      @(posedge clk) begin go <= 1'b1; nf <= n; end
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
      k = 0;
      while (busy !== 1'b0 && k < 500) begin @(posedge clk); k++; end
      if (k >= 500) begin n_errors++; conclude(); end
   endtask : line
   function automatic logic [7:0] eadd(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction : eadd

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude();
   end

   initial begin
      {nrst, psel, penable, pwrite, brk, go} = '0;
      paddr = '0; pwdata = '0; tx_ev = '0; rx_ev = '0; cev = '0; p1 = '0; p2 = '0; nf = '0;
      msk = '{UACS_MSK_P3L, UACS_MSK_P3H, UACS_MSK_SUM, UACS_MSK_SUM, UACS_MSK_SCCFG,
              UACS_MSK_SCIRQ, UACS_MSK_WAKEAB, UACS_MSK_CTRL};
      cv = '{16'h0003, 16'h0024, 16'h0000, 16'h0020, 16'h0021, 16'h0002};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) rdc("reset value", 8'(i * 4), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 8'(i * 4), 16'hFFFF);
         rdc("writable bits", 8'(i * 4), msk[i]);
      end
      @(negedge clk);
      chk("wait time", 24'hFFFFFF, wt);
      chk("event irq", 1, eirq);
      apb(1'b1, UACS_OFF_P3L, 16'h0B5A);
      @(negedge clk);
      chk("dmx last index", 9'h15A, dmx);
      chk("lin count", 8'h5A, linc);
      chk("address mask", 8'h5A, amsk);
      for (int i = 0; i < 8; i++) apb(1'b1, 8'(i * 4), 16'h0000);
      @(negedge clk);
      chk("event irq clear", 0, eirq);
      rdc("unmapped", 8'h20, 16'h0000);
      rdc("unaligned", 8'h02, 16'h0000);
      $display("register test done");
      foreach (cv[c]) begin
         apb(1'b1, UACS_OFF_CTRL, cv[c]);
         apb(1'b1, UACS_OFF_TXSUM, 16'h0011);
         apb(1'b1, UACS_OFF_RXSUM, 16'h0011);
         e = 8'h11;
         if (cv[c][2:0] == 3'h3 || cv[c][2:0] == 3'h4) begin
            @(posedge clk) brk <= 1'b1;
            @(posedge clk) brk <= 1'b0;
            e = 8'h00;
         end
         bev(1'b1, 8'hC1);
         bev(1'b0, 8'hF0);
         bev(1'b0, 8'h35);
         if (cv[c][5]) e = eadd(e, 8'hC1);
         if (cv[c][5] || e != 8'h11) begin e = eadd(e, 8'hF0); e = eadd(e, 8'h35); end
         rdc("tx sum", UACS_OFF_TXSUM, {8'h00, e});
         rdc("rx sum", UACS_OFF_RXSUM, {8'h00, e});
      end
      $display("checksum test done");
      apb(1'b1, UACS_OFF_CTRL, 16'h0005);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, UACS_OFF_SCCFG, 16'((r << 4) | ((r & 1) << 3) | ((r >> 1) << 1)));
         @(negedge clk);
         chk("convention", r & 1, inv);
         chk("protocol", r >> 1, t1);
         bev(1'b0, 8'h3B);
         @(negedge clk);
         chk("card data", (r & 1) ? 8'h23 : 8'h3B, crx);
         n_retx = 0;
         repeat (r + 2) cp(8'h02);
         repeat (2) @(posedge clk);
         chk("resends", r + 1, n_retx);
         rdc("tx repeat flag", UACS_OFF_SCIRQ, 16'h1000);
         apb(1'b1, UACS_OFF_SCIRQ, 16'h0000);
      end
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, UACS_OFF_SCCFG, 16'(p << 2));
         repeat (4) cp(8'h08);
         rdc("rx repeat early", UACS_OFF_SCIRQ, 16'h0000);
         cp(8'h08);
         rdc("rx repeat flag", UACS_OFF_SCIRQ, 16'h2000);
         lowticks = 0;
         repeat (4) cp(8'h80);
         chk("pull-down ticks", p + 1, lowticks);
         apb(1'b1, UACS_OFF_SCIRQ, 16'h0000);
      end
      apb(1'b1, UACS_OFF_SCCFG, 16'h0006);
      cp(8'h08);
      @(negedge clk);
      chk("no pull-down in T=1", 0, llow);
      $display("repeat test done");
      p1 <= 9'h003;
      p2 <= 9'h002;
      apb(1'b1, UACS_OFF_P3L, 16'h0004);
      cp(8'h70);
      repeat (2) cp(8'h80);
      rdc("block timer", UACS_OFF_SCIRQ, 16'h0400);
      cp(8'h80);
      rdc("guard timer", UACS_OFF_SCIRQ, 16'h0500);
      cp(8'h80);
      rdc("wait timer", UACS_OFF_SCIRQ, 16'h0700);
      chk("card irq masked", 0, cirq);
      apb(1'b1, UACS_OFF_SCIRQ, 16'h0702);
      @(negedge clk);
      chk("card irq enabled", 1, cirq);
      $display("timer test done");
      apb(1'b1, UACS_OFF_CTRL, 16'h0008);
      line(3'd1);
      rdc("wake flag", UACS_OFF_WAKEAB, 16'h0080);
      chk("wake irq", 1, eirq);
      apb(1'b1, UACS_OFF_WAKEAB, 16'h0004);
      apb(1'b1, UACS_OFF_CTRL, 16'h0010);
      n_abd = 0;
      line(3'd5);
      chk("auto-baud pulses", 1, n_abd);
      rdc("auto-baud flag", UACS_OFF_WAKEAB, 16'h0044);
      chk("auto-baud irq", 1, eirq);
      apb(1'b1, UACS_OFF_WAKEAB, 16'h0040);
      @(negedge clk);
      chk("auto-baud irq masked", 0, eirq);
      $display("wake test done");
      conclude();
   end
endmodule : uacs_core_tb

bind uacs_core uacs_checker i_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .CARD_EV(CARD_EV), .DMX_LAST_IDX(DMX_LAST_IDX), .LIN_RX_COUNT(LIN_RX_COUNT), .ADDR_MASK(ADDR_MASK),
   .WAIT_TIME(WAIT_TIME), .CARD_RETX_REQ(CARD_RETX_REQ), .CARD_LINE_LOW(CARD_LINE_LOW),
   .AUTOBAUD_DONE(AUTOBAUD_DONE));
`default_nettype wire
